//--- design/core_pkg.sv
// Shared types and constants for the integer pipeline core.
package core_pkg;

  localparam int          XLEN      = 64;
  localparam int          NREG      = 32;
  localparam logic [63:0] PC_RESET  = 64'h0;
  localparam logic [63:0] PC_STEP   = 64'h4;
  localparam logic [6:0]  MUL32_CYC = 7'd6;
  localparam logic [6:0]  MUL64_CYC = 7'd7;
  localparam logic [6:0]  DIV32_CYC = 7'd42;
  localparam logic [6:0]  DIV64_CYC = 7'd74;

  // Instruction word fields.
  localparam int OPC_MSB = 31;
  localparam int OPC_LSB = 26;
  localparam int RS_LSB  = 21;
  localparam int RT_LSB  = 16;
  localparam int RD_LSB  = 11;

  typedef enum logic [5:0] {
    OP_NOP   = 6'b000000,
    OP_ADD   = 6'b000001,
    OP_SUB   = 6'b000010,
    OP_AND   = 6'b000011,
    OP_OR    = 6'b000100,
    OP_XOR   = 6'b000101,
    OP_SLL   = 6'b000110,
    OP_SRL   = 6'b000111,
    OP_ADDI  = 6'b001000,
    OP_LD    = 6'b001001,
    OP_SD    = 6'b001010,
    OP_BEQ   = 6'b001011,
    OP_MUL32 = 6'b001100,
    OP_MUL64 = 6'b001101,
    OP_DIV32 = 6'b001110,
    OP_DIV64 = 6'b001111,
    OP_MFRH  = 6'b010000,
    OP_MFRL  = 6'b010001
  } opcode_t;

  localparam logic [5:0] OP_LAST = 6'b010001;

  typedef enum logic {
    MD_IDLE = 1'b0,
    MD_BUSY = 1'b1
  } md_state_t;

  typedef struct packed {
    opcode_t     op;
    logic [4:0]  rd;
    logic [4:0]  rs;
    logic [4:0]  rt;
    logic [15:0] imm;
  } dec_t;

  typedef struct packed {
    logic        valid;
    dec_t        d;
    logic [63:0] a;
    logic [63:0] b;
    logic [63:0] target;
  } ex_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        wen;
    logic [4:0]  dst;
    logic [63:0] val;
    logic [63:0] sdata;
  } mem_t;

  typedef struct packed {
    logic        wen;
    logic [4:0]  dst;
    logic [63:0] val;
  } wb_t;

  typedef struct packed {
    logic        valid;
    opcode_t     op;
    logic [63:0] a;
    logic [63:0] b;
  } md_req_t;

  typedef struct packed {
    logic        done;
    logic [63:0] hi;
    logic [63:0] lo;
  } md_rsp_t;

endpackage : core_pkg

//--- design/integer_pipeline_core.sv
// Five-stage 64-bit integer pipeline with full bypass and result registers.
`timescale 1ns/10ps

// Overview of operation
// - Five stages, several instructions in flight.
// - Translation overlaps cache lookup, not before.
// - Thirty-two general registers for data, addresses.
// - Register file: two reads, one write.
// - Unwritten results bypassed to every operand.
// - Simple ops single cycle; memory by load/store.
// - Adder does arithmetic, addresses; logic unit rest.
// - Multiply and divide run on coprocessor hardware.
// - Multiply/divide results land in high, low.
// - Move-from copies high or low to register.
// - Early move after multiply stalls, 6 or 7 cycles.
// - Divide takes 42 or 74; early moves interlock.
// - Instruction translation overlaps instruction cache fetch.
// - Read stage: registers, bypass, decode, branch target.
// - Execute start: issue/slip, data address, branch.
// - Execute yields add/logic/shift; store aligned there; core sends store data unaligned.
// - Data cache, translation, load align in data stage; core passes load data unaligned.
// - Joint translation spans whole data stage.
// - Register file written in write-back stage.
// - Coprocessor runs concurrently, owns its registers.
module integer_pipeline_core #(
  parameter logic [63:0] RESET_PC = core_pkg::PC_RESET
) (
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  output logic [63:0]            imem_vaddr_out,
  input  wire logic [31:0]       imem_data_in,
  input  wire logic              imem_hit_in,
  output logic                   dmem_rd_out,
  output logic                   dmem_wr_out,
  output logic [63:0]            dmem_vaddr_out,
  output logic [63:0]            dmem_wdata_out,
  input  wire logic [63:0]       dmem_rdata_in,
  input  wire logic              dmem_hit_in,
  output core_pkg::md_req_t      md_req_out,
  input  wire core_pkg::md_rsp_t md_rsp_in
);
  import core_pkg::*;

  function automatic dec_t decode(input logic [31:0] w);
    dec_t d;
    d.op  = (w[OPC_MSB:OPC_LSB] > OP_LAST) ? OP_NOP
                                           : opcode_t'(w[OPC_MSB:OPC_LSB]);
    d.rs  = w[RS_LSB +: 5];
    d.rt  = w[RT_LSB +: 5];
    d.rd  = w[RD_LSB +: 5];
    d.imm = w[15:0];
    return d;
  endfunction : decode

  // Returns the write enable and destination index of an instruction.
  function automatic logic [5:0] dest_of(input dec_t d);
    logic [4:0] r;
    r = 5'd0;
    case (d.op)
      OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_SLL, OP_SRL,
      OP_MFRH, OP_MFRL: r = d.rd;
      OP_ADDI, OP_LD:   r = d.rt;
      default:          r = 5'd0;
    endcase
    return {(r != 5'd0), r};
  endfunction : dest_of

  function automatic logic is_md(input opcode_t op);
    return (op == OP_MUL32) || (op == OP_MUL64) ||
           (op == OP_DIV32) || (op == OP_DIV64);
  endfunction : is_md

  function automatic logic [6:0] md_cycles(input opcode_t op);
    case (op)
      OP_MUL32: return MUL32_CYC;
      OP_MUL64: return MUL64_CYC;
      OP_DIV32: return DIV32_CYC;
      default:  return DIV64_CYC;
    endcase
  endfunction : md_cycles

  function automatic logic [63:0] sext(input logic [15:0] v);
    return {{48{v[15]}}, v};
  endfunction : sext

  // The adder serves arithmetic and load/store address calculation.
  function automatic logic [63:0] adder_unit(input opcode_t op,
                                             input logic [63:0] a,
                                             input logic [63:0] b);
    return (op == OP_SUB) ? a - b : a + b;
  endfunction : adder_unit

  function automatic logic [63:0] logic_unit(input opcode_t op,
                                             input logic [63:0] a,
                                             input logic [63:0] b,
                                             input logic [5:0] sh);
    case (op)
      OP_AND:  return a & b;
      OP_OR:   return a | b;
      OP_XOR:  return a ^ b;
      OP_SLL:  return a << sh;
      OP_SRL:  return a >> sh;
      default: return 64'h0;
    endcase
  endfunction : logic_unit

  function automatic logic [63:0] bypass(input logic [4:0] r,
                                         input logic [63:0] rf,
                                         input logic [5:0] exd,
                                         input logic [63:0] exv,
                                         input logic [5:0] memd,
                                         input logic [63:0] memv,
                                         input wb_t wb);
    if (r == 5'd0) begin
      return 64'h0;
    end else if (exd[5] && exd[4:0] == r) begin
      return exv;
    end else if (memd[5] && memd[4:0] == r) begin
      return memv;
    end else if (wb.wen && wb.dst == r) begin
      return wb.val;
    end else begin
      return rf;
    end
  endfunction : bypass

  logic [63:0] gpr [NREG];
  logic [63:0] pc;
  logic [63:0] id_pc;
  logic [31:0] id_instr;
  logic        id_valid;
  ex_t         ex;
  mem_t        mem;
  wb_t         wb;
  logic [63:0] result_high_reg;
  logic [63:0] result_low_reg;
  md_state_t   md_state;
  logic [6:0]  md_count;
  logic        md_got;

  dec_t        id_dec;
  logic [63:0] rf_a;
  logic [63:0] rf_b;
  logic [63:0] next_a;
  logic [63:0] next_b;
  logic [5:0]  ex_dst;
  logic [63:0] ex_res;
  logic [63:0] ex_opb;
  logic        ex_taken;
  logic [63:0] mem_res;
  logic        load_use;
  logic        move_wait;
  logic        md_wait;
  logic        slip;
  logic        hold_all;
  logic        md_issue;
  logic        move_from_result_high;
  logic        move_from_result_low;

  // Outputs are the fetch counter and data stage flops themselves.
  assign imem_vaddr_out = pc;
  assign dmem_rd_out    = mem.rd;
  assign dmem_wr_out    = mem.wr;
  assign dmem_vaddr_out = mem.val;
  assign dmem_wdata_out = mem.sdata;

  // A miss on the data cache or its translation freezes the whole pipe.
  assign hold_all = (mem.rd || mem.wr) && !dmem_hit_in;

  always_comb begin
    id_dec = decode(id_instr);
    rf_a   = gpr[id_dec.rs];
    rf_b   = gpr[id_dec.rt];
    ex_dst = ex.valid ? dest_of(ex.d) : 6'h0;
  end

  assign move_from_result_high = id_valid && id_dec.op == OP_MFRH;
  assign move_from_result_low  = id_valid && id_dec.op == OP_MFRL;

  // Load data is not known until the data stage, so a user slips one cycle.
  assign load_use = id_valid && ex.valid && ex.d.op == OP_LD && ex_dst[5] &&
                    (ex_dst[4:0] == id_dec.rs || ex_dst[4:0] == id_dec.rt);
  assign move_wait = (move_from_result_high || move_from_result_low) &&
                     (md_state == MD_BUSY ||
                      (ex.valid && is_md(ex.d.op)));
  assign md_wait = id_valid && is_md(id_dec.op) &&
                   (md_state == MD_BUSY || (ex.valid && is_md(ex.d.op)));
  assign slip = load_use || move_wait || md_wait;

  // Execute stage: adder and logic unit each finish in one cycle.
  always_comb begin
    ex_opb = ex.b;
    if (ex.d.op == OP_ADDI || ex.d.op == OP_LD || ex.d.op == OP_SD) begin
      ex_opb = sext(ex.d.imm);
    end
    case (ex.d.op)
      OP_ADD, OP_SUB, OP_ADDI, OP_LD, OP_SD:
        ex_res = adder_unit(ex.d.op, ex.a, ex_opb);
      OP_AND, OP_OR, OP_XOR, OP_SLL, OP_SRL:
        ex_res = logic_unit(ex.d.op, ex.a, ex.b,
                            ex.d.imm[5:0]);
      OP_MFRH: ex_res = result_high_reg;
      OP_MFRL: ex_res = result_low_reg;
      default: ex_res = 64'h0;
    endcase
    ex_taken = ex.valid && ex.d.op == OP_BEQ && ex.a == ex.b;
    md_issue = ex.valid && is_md(ex.d.op) && !hold_all;
  end

  // Load data is forwarded straight out of the data stage, with no alignment.
  assign mem_res = mem.rd ? dmem_rdata_in : mem.val;

  always_comb begin
    next_a = bypass(id_dec.rs, rf_a, ex_dst, ex_res,
                    {mem.wen, mem.dst}, mem_res, wb);
    next_b = bypass(id_dec.rt, rf_b, ex_dst, ex_res,
                    {mem.wen, mem.dst}, mem_res, wb);
  end

  // Fetch: translation and cache answer in the cycle the address stands.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pc <= RESET_PC;
    end else if (hold_all) begin
      pc <= pc;
    end else if (ex_taken) begin
      // A taken branch wins over a slip, since the slipping one is killed.
      pc <= ex.target;
    end else if (slip) begin
      pc <= pc;
    end else if (imem_hit_in) begin
      pc <= pc + PC_STEP;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      id_valid <= 1'b0;
      id_instr <= 32'h0;
      id_pc    <= 64'h0;
    end else if (!hold_all && (ex_taken || (!slip && !imem_hit_in))) begin
      id_valid <= 1'b0;
      id_instr <= 32'h0;
    end else if (!hold_all && !slip) begin
      id_valid <= 1'b1;
      id_instr <= imem_data_in;
      id_pc    <= pc;
    end
  end

  // Read stage to execute stage, with bypassed operands.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ex <= '0;
    end else if (!hold_all) begin
      if (slip || ex_taken || !id_valid) begin
        ex <= '0;
      end else begin
        ex.valid  <= 1'b1;
        ex.d      <= id_dec;
        ex.a      <= next_a;
        ex.b      <= next_b;
        ex.target <= id_pc + PC_STEP +
                     {{46{id_dec.imm[15]}}, id_dec.imm, 2'b00};
      end
    end
  end

  // Only loads and stores reach the data port.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mem <= '0;
    end else if (!hold_all) begin
      mem.rd    <= ex.valid && ex.d.op == OP_LD;
      mem.wr    <= ex.valid && ex.d.op == OP_SD;
      mem.wen   <= ex_dst[5];
      mem.dst   <= ex_dst[4:0];
      mem.val   <= ex_res;
      mem.sdata <= ex.b;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wb <= '0;
    end else if (!hold_all) begin
      wb.wen <= mem.wen;
      wb.dst <= mem.dst;
      wb.val <= mem_res;
    end else begin
      wb.wen <= 1'b0;
    end
  end

  // The write lands at the clock edge; same-cycle readers use the bypass.
  always_ff @(posedge clk_in) begin
    if (wb.wen) begin
      gpr[wb.dst] <= wb.val;
    end
  end

  // Multiply/divide requests go to the coprocessor's execution hardware.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      md_req_out <= '0;
    end else begin
      md_req_out.valid <= md_issue;
      if (md_issue) begin
        md_req_out.op <= ex.d.op;
        md_req_out.a  <= ex.a;
        md_req_out.b  <= ex.b;
      end
    end
  end

  // Busy lasts until both the minimum count and the answer have come.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      md_state <= MD_IDLE;
      md_count <= 7'd0;
      md_got   <= 1'b0;
    end else begin
      case (md_state)
        MD_IDLE: begin
          if (md_issue) begin
            md_state <= MD_BUSY;
            md_count <= md_cycles(ex.d.op);
            md_got   <= 1'b0;
          end
        end
        MD_BUSY: begin
          if (md_count != 7'd0) begin
            md_count <= md_count - 7'd1;
          end
          if (md_rsp_in.done) begin
            md_got <= 1'b1;
          end
          if (md_count == 7'd0 && (md_got || md_rsp_in.done)) begin
            md_state <= MD_IDLE;
          end
        end
        default: md_state <= MD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      result_high_reg <= 64'h0;
      result_low_reg  <= 64'h0;
    end else if (md_state == MD_BUSY && md_rsp_in.done) begin
      result_high_reg <= md_rsp_in.hi;
      result_low_reg  <= md_rsp_in.lo;
    end
  end

endmodule : integer_pipeline_core

//--- sim/core_checker.sv
// Port-level assertions for the integer pipeline core.
`timescale 1ns/10ps
module core_checker
  import core_pkg::*;
#(
  parameter logic [63:0] RESET_PC = core_pkg::PC_RESET
) (
  input wire logic              clk_in,
  input wire logic              resetn_in,
  input wire logic [63:0]       imem_vaddr_out,
  input wire logic [31:0]       imem_data_in,
  input wire logic              imem_hit_in,
  input wire logic              dmem_rd_out,
  input wire logic              dmem_wr_out,
  input wire logic [63:0]       dmem_vaddr_out,
  input wire logic [63:0]       dmem_wdata_out,
  input wire logic [63:0]       dmem_rdata_in,
  input wire logic              dmem_hit_in,
  input wire core_pkg::md_req_t md_req_out,
  input wire core_pkg::md_rsp_t md_rsp_in
);
  logic [6:0] since;
  logic [6:0] need;
  logic       dwait;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  assign dwait = (dmem_rd_out || dmem_wr_out) && !dmem_hit_in;

  // The count saturates so a long idle spell cannot wrap into a false alarm.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      since <= 7'h7f;
      need  <= 7'h00;
    end else if (md_req_out.valid) begin
      since <= 7'h01;
      case (md_req_out.op)
        OP_MUL32: need <= MUL32_CYC;
        OP_MUL64: need <= MUL64_CYC;
        OP_DIV32: need <= DIV32_CYC;
        default:  need <= DIV64_CYC;
      endcase
    end else if (since != 7'h7f) begin
      since <= since + 7'h01;
    end
  end

  a_reset_quiet: assert property (disable iff (1'b0)
    !resetn_in |-> !dmem_rd_out && !dmem_wr_out && !md_req_out.valid &&
    imem_vaddr_out == RESET_PC) else $error("outputs active in reset");
  a_first_fetch: assert property (
    $rose(resetn_in) && imem_hit_in |=> imem_vaddr_out == RESET_PC + PC_STEP)
    else $error("first fetch did not advance");
  a_pc_align: assert property (imem_vaddr_out[1:0] == 2'b00)
    else $error("fetch address not word aligned");
  a_one_access: assert property (!(dmem_rd_out && dmem_wr_out))
    else $error("load and store together");
  a_data_stand: assert property (
    dwait |=> $stable(dmem_vaddr_out) && $stable(dmem_wdata_out) &&
    $stable(dmem_rd_out) && $stable(dmem_wr_out))
    else $error("data request dropped before hit");
  a_pipe_freeze: assert property (dwait |=> $stable(imem_vaddr_out))
    else $error("fetch moved during data wait");
  a_md_pulse: assert property (
    md_req_out.valid |=> !md_req_out.valid) else $error("request not a pulse");
  a_md_stand: assert property (
    !md_req_out.valid |-> $stable(md_req_out.a) && $stable(md_req_out.b))
    else $error("operands changed without request");
  a_md_spacing: assert property (md_req_out.valid |-> since > need)
    else $error("multiply or divide issued while busy");
  a_md_ops: assert property (md_req_out.valid |-> md_req_out.op inside
    {OP_MUL32, OP_MUL64, OP_DIV32, OP_DIV64}) else $error("bad unit opcode");

  c_div64: cover property (md_req_out.valid && md_req_out.op == OP_DIV64);
  c_dwait: cover property (dmem_rd_out && !dmem_hit_in);
  c_store: cover property (dmem_wr_out && dmem_hit_in);
endmodule : core_checker

bind integer_pipeline_core core_checker #(.RESET_PC(RESET_PC)) chk (
  .clk_in(clk_in), .resetn_in(resetn_in), .imem_vaddr_out(imem_vaddr_out),
  .imem_data_in(imem_data_in), .imem_hit_in(imem_hit_in),
  .dmem_rd_out(dmem_rd_out), .dmem_wr_out(dmem_wr_out),
  .dmem_vaddr_out(dmem_vaddr_out), .dmem_wdata_out(dmem_wdata_out),
  .dmem_rdata_in(dmem_rdata_in), .dmem_hit_in(dmem_hit_in),
  .md_req_out(md_req_out), .md_rsp_in(md_rsp_in));

//--- sim/core_partner.sv
// Far-side model: fetch and data memories plus the multiply/divide unit.
`timescale 1ns/10ps
module core_partner (
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  input  wire logic              slow_in,
  input  wire logic [63:0]       imem_vaddr_in,
  output logic [31:0]            imem_data_out,
  output logic                   imem_hit_out,
  input  wire logic              dmem_rd_in,
  input  wire logic              dmem_wr_in,
  input  wire logic [63:0]       dmem_vaddr_in,
  input  wire logic [63:0]       dmem_wdata_in,
  output logic [63:0]            dmem_rdata_out,
  output logic                   dmem_hit_out,
  input  wire core_pkg::md_req_t md_req_in,
  output core_pkg::md_rsp_t      md_rsp_out
);
  import core_pkg::*;
  logic [31:0]  prog [64];
  logic [63:0]  dmem [32];
  logic         iw;
  logic         dw;
  logic [6:0]   cnt;
  logic [6:0]   need;
  logic [127:0] res;
  logic [63:0]  a;
  logic [63:0]  b;

  // In slow mode fetches and data accesses miss once each; a miss shows
  // inverted data so a stale word can never pass for a good one.
  assign imem_hit_out    = !slow_in || iw;
  assign imem_data_out   = imem_hit_out ? prog[imem_vaddr_in[7:2]]
                                        : ~prog[imem_vaddr_in[7:2]];
  assign dmem_hit_out    = (dmem_rd_in || dmem_wr_in) && (!slow_in || dw);
  assign dmem_rdata_out  = dmem_hit_out ? dmem[dmem_vaddr_in[7:3]]
                                        : ~dmem[dmem_vaddr_in[7:3]];
  assign md_rsp_out.done = (cnt == 7'h01);
  assign md_rsp_out.hi   = md_rsp_out.done ? res[127:64] : ~res[127:64];
  assign md_rsp_out.lo   = md_rsp_out.done ? res[63:0] : ~res[63:0];
  assign a               = md_req_in.a;
  assign b               = md_req_in.b;
  assign need = (md_req_in.op == OP_MUL32) ? MUL32_CYC :
                (md_req_in.op == OP_MUL64) ? MUL64_CYC :
                (md_req_in.op == OP_DIV32) ? DIV32_CYC : DIV64_CYC;

  always @(posedge clk_in) begin
    iw <= !imem_hit_out;
    dw <= (dmem_rd_in || dmem_wr_in) && !dmem_hit_out;
    if (dmem_wr_in && dmem_hit_out) begin
      dmem[dmem_vaddr_in[7:3]] <= dmem_wdata_in;
    end
  end

  // Slow mode answers past the minimum count, so the core must wait for done.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt <= 7'h00;
    end else if (md_req_in.valid) begin
      case (md_req_in.op)
        OP_MUL32: res <= a[31:0] * b[31:0];
        OP_MUL64: res <= a * b;
        OP_DIV32: res <= {64'(a[31:0] % b[31:0]), 64'(a[31:0] / b[31:0])};
        default:  res <= {a % b, a / b};
      endcase
      cnt <= need + (slow_in ? 7'h03 : 7'h00);
    end else if (cnt != 7'h00) begin
      cnt <= cnt - 7'h01;
    end
  end
endmodule : core_partner

//--- sim/integer_pipeline_core_tb.sv
// Self-checking testbench for the integer pipeline core.
`timescale 1ns/10ps
module integer_pipeline_core_tb;
  import core_pkg::*;
  logic        clk_in, resetn_in, slow, imem_hit, dmem_rd, dmem_wr, dmem_hit;
  logic [31:0] imem_data;
  logic [63:0] imem_vaddr, dmem_vaddr, dmem_wdata, dmem_rdata;
  md_req_t     md_req;
  md_rsp_t     md_rsp;
  int          error_cnt = 0;
  int          n_checks = 0;
  int          cycles = 0;
  logic [31:0] p [$];

  integer_pipeline_core dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .imem_vaddr_out(imem_vaddr),
    .imem_data_in(imem_data), .imem_hit_in(imem_hit), .dmem_rd_out(dmem_rd),
    .dmem_wr_out(dmem_wr), .dmem_vaddr_out(dmem_vaddr),
    .dmem_wdata_out(dmem_wdata), .dmem_rdata_in(dmem_rdata),
    .dmem_hit_in(dmem_hit), .md_req_out(md_req), .md_rsp_in(md_rsp));

  core_partner part (
    .clk_in(clk_in), .resetn_in(resetn_in), .slow_in(slow),
    .imem_vaddr_in(imem_vaddr), .imem_data_out(imem_data),
    .imem_hit_out(imem_hit), .dmem_rd_in(dmem_rd), .dmem_wr_in(dmem_wr),
    .dmem_vaddr_in(dmem_vaddr), .dmem_wdata_in(dmem_wdata),
    .dmem_rdata_out(dmem_rdata), .dmem_hit_out(dmem_hit),
    .md_req_in(md_req), .md_rsp_out(md_rsp));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  function automatic logic [31:0] ins(opcode_t op, int rs, int rt, int rd,
                                      int imm);
    return {op, rs[4:0], rt[4:0], imm[15:0]} | {16'h0, rd[4:0], 11'h0};
  endfunction : ins

  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Loads the program, resets the core and waits for the closing store.
  task automatic run_prog(input logic slow_mode);
    int n;
    n = 0;
    p.push_back(ins(OP_SD, 0, 0, 0, 248));
    @(posedge clk_in);
    resetn_in <= 1'b0;
    slow      <= slow_mode;
    foreach (part.prog[i]) part.prog[i] = (i < p.size()) ? p[i] : 32'h0;
    foreach (part.dmem[i]) part.dmem[i] = 64'h0;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    do begin
      @(negedge clk_in);
      n++;
    end while (!(dmem_wr === 1'b1 && dmem_hit === 1'b1 &&
                 dmem_vaddr === 64'hf8) && n < 800);
    check("end marker", 64'(n < 800), 64'h1);
  endtask : run_prog

  task automatic t_alu();
    logic [63:0] exp [7] = '{64'h8, 64'h3, 64'h80, 64'h83, 64'h1, 64'h20,
                             64'h7};
    p = '{ins(OP_ADDI, 0, 1, 0, 5), ins(OP_ADDI, 0, 2, 0, 3),
          ins(OP_ADD, 1, 2, 3, 0), ins(OP_SUB, 3, 1, 4, 0),
          ins(OP_SLL, 3, 0, 5, 4), ins(OP_XOR, 5, 4, 6, 0),
          ins(OP_AND, 6, 1, 7, 0), ins(OP_SRL, 5, 0, 8, 2),
          ins(OP_OR, 4, 1, 9, 0),
          // A taken branch must redirect even while a move slips behind it.
          ins(OP_MUL32, 1, 2, 0, 0), ins(OP_BEQ, 0, 0, 0, 2),
          ins(OP_MFRL, 0, 0, 9, 0), ins(OP_ADDI, 0, 9, 0, 1)};
    for (int r = 9; r >= 3; r--) begin
      p.push_back(ins(OP_SD, 0, r, 0, r * 8));
    end
    run_prog(1'b0);
    for (int r = 3; r <= 9; r++) begin
      check("alu result", part.dmem[r], exp[r - 3]);
    end
    $display("alu and bypass test done");
  endtask : t_alu

  task automatic t_muldiv();
    logic [63:0] exp [6] = '{64'h4000000000000000, 64'h5, 64'he, 64'h2,
                             64'he, 64'h2};
    p = '{ins(OP_ADDI, 0, 1, 0, 100), ins(OP_ADDI, 0, 2, 0, 7),
          ins(OP_SLL, 2, 0, 3, 62), ins(OP_MUL64, 3, 2, 0, 0),
          ins(OP_MFRL, 0, 0, 5, 0), ins(OP_MFRH, 0, 0, 6, 0),
          ins(OP_DIV32, 1, 2, 0, 0), ins(OP_MFRL, 0, 0, 7, 0),
          ins(OP_MFRH, 0, 0, 8, 0), ins(OP_MUL32, 1, 2, 0, 0),
          ins(OP_DIV64, 1, 2, 0, 0), ins(OP_MFRL, 0, 0, 9, 0),
          ins(OP_MFRH, 0, 0, 10, 0)};
    for (int r = 5; r <= 10; r++) begin
      p.push_back(ins(OP_SD, 0, r, 0, r * 8));
    end
    run_prog(1'b1);
    for (int r = 5; r <= 10; r++) begin
      check("muldiv result", part.dmem[r], exp[r - 5]);
    end
    $display("multiply and divide test done");
  endtask : t_muldiv

  task automatic t_load_branch();
    p = '{ins(OP_ADDI, 0, 1, 0, 64), ins(OP_ADDI, 0, 4, 0, 9),
          ins(OP_SD, 1, 1, 0, 0), ins(OP_LD, 1, 2, 0, 0),
          ins(OP_ADD, 2, 2, 3, 0), 32'hfc000000, ins(OP_BEQ, 3, 0, 0, 1),
          ins(OP_BEQ, 3, 3, 0, 1), ins(OP_ADDI, 0, 4, 0, 1),
          ins(OP_SD, 0, 3, 0, 24), ins(OP_SD, 0, 4, 0, 32)};
    run_prog(1'b1);
    check("stored word", part.dmem[8], 64'h40);
    check("load sum", part.dmem[3], 64'h80);
    check("branch skip", part.dmem[4], 64'h9);
    $display("load and branch test done");
  endtask : t_load_branch

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    resetn_in = 1'b0;
    slow      = 1'b0;
    repeat (12) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_alu();
    t_muldiv();
    t_load_branch();
    report_and_stop();
  end
endmodule : integer_pipeline_core_tb
